// [rtl/hfcr_regs.svh]
// Register offsets, field positions, reset values and timing constants
`ifndef HFCR_REGS_SVH
`define HFCR_REGS_SVH

`define HFCR_ADDR_W 8
`define HFCR_FEATURE_OFS 8'hF0
`define HFCR_COMMAND_OFS 8'hF8
`define HFCR_FEATURE_RST 8'h00
`define HFCR_COMMAND_RST 8'h00

`define HFCR_FEAT_IND_EN_BIT 4
`define HFCR_FEAT_DELAY_MSB 3
`define HFCR_FEAT_DELAY_LSB 1
`define HFCR_FEAT_SSC_DIS_BIT 0
`define HFCR_CMD_RELOAD_BIT 1
`define HFCR_CMD_CFG_BIT 0

`define HFCR_CLK_HZ 10000000
`define HFCR_DELAY_STEP_MS 200
`define HFCR_STEP_CYCLES ((`HFCR_CLK_HZ / 1000) * `HFCR_DELAY_STEP_MS)
`define HFCR_RELOAD_CYCLES 2

`endif

// [rtl/hfcr_pkg.sv]
// Types shared by the feature and command register bank
package hfcr_pkg;
   typedef enum logic [1:0] {
      HFCR_PWR_ON,
      HFCR_PWR_OFF_WAIT
   } hfcr_pwr_state_t;

   typedef enum logic [1:0] {
      HFCR_RLD_IDLE,
      HFCR_RLD_BUSY
   } hfcr_reload_state_t;
endpackage

// [rtl/hfcr_step_timer.sv]
// Free-running divider producing one-cycle step-enable pulses
`timescale 1ns/10ps
`include "hfcr_regs.svh"
module hfcr_step_timer #(
   parameter int unsigned STEP_CYCLES = `HFCR_STEP_CYCLES
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // Control
   input wire logic restart_i,
   output logic step_o
);
   initial begin
      if (STEP_CYCLES < 2) begin
         $error("hfcr_step_timer: STEP_CYCLES must be at least 2");
      end
   end

   logic [31:0] cnt_r;
   logic [31:0] cnt_nxt;
   logic step_r;
   logic step_nxt;

   always_comb begin
      cnt_nxt = cnt_r + 32'h0000_0001;
      step_nxt = 1'b0;
      if (restart_i) begin
         cnt_nxt = 32'h0000_0000;
      end else if (cnt_r == STEP_CYCLES - 1) begin
         cnt_nxt = 32'h0000_0000;
         step_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         cnt_r <= 32'h0000_0000;
         step_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         step_r <= step_nxt;
      end
   end

   assign step_o = step_r;
endmodule

// [rtl/hfcr_feature_cmd_regs.sv]
// Hub feature and command registers with port-power re-enable timing
//
// Overview of operation
// - Reserved upper bits read zero; writes to them are dropped.
// - Indicator enable low tri-states four status outputs; high drives them.
// - Indicator enable and delay field writable from EEPROM or SMBus host.
// - With OTP delay field zero, register bits 3:1 set power re-enable delay.
// - Re-enable delay is (field plus one) times 200 ms.
// - Bit 0 of feature register disables PHY spread spectrum when set.
// - Writing 1 to command bit 1 reloads all registers to defaults.
// - Reload bit self-clears after reload; writing 0 does nothing.
// - Config-in-progress flag set on entering I2C or SMBus config mode.
// - Upstream connect held off while config-in-progress reads 1.
// - Host writes 1 to clear config-in-progress; writing 0 ignored.
// - Command register at F8h, reset to all zero.
// - Feature register at F0h, reset to all zero.
`timescale 1ns/10ps
`include "hfcr_regs.svh"
module hfcr_feature_cmd_regs #(
   parameter int unsigned STEP_CYCLES = `HFCR_STEP_CYCLES,
   parameter int unsigned NUM_IND = 4
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // Register access from SMBus slave or EEPROM loader
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [`HFCR_ADDR_W-1:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   // Configuration mode and OTP
   input wire logic cfg_mode_enter_i,
   input wire logic [2:0] otp_power_reenable_delay_i,
   // Charging mode change request, port power and reload status
   input wire logic charge_mode_change_i,
   output logic port_power_switch_enable_o,
   output logic reload_busy_o,
   // Indicator pins: high_speed, high_speed_suspend, super_speed, super_speed_suspend
   input wire logic [NUM_IND-1:0] indicator_i,
   output logic [NUM_IND-1:0] indicator_o,
   output logic [NUM_IND-1:0] indicator_oe_o,
   // Status to hub core
   output logic phy_ssc_disable_o,
   output logic upstream_connect_allow_o,
   output logic config_in_progress_o
);
   initial begin
      if (NUM_IND != 4) begin
         $error("hfcr_feature_cmd_regs: NUM_IND must be 4");
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register state
   logic indicator_output_enable_r;
   logic indicator_output_enable_nxt;
   logic [2:0] power_reenable_delay_r;
   logic [2:0] power_reenable_delay_nxt;
   logic phy_ssc_disable_r;
   logic phy_ssc_disable_nxt;
   logic config_in_progress_r;
   logic config_in_progress_nxt;
   hfcr_pkg::hfcr_reload_state_t reload_state_r;
   hfcr_pkg::hfcr_reload_state_t reload_state_nxt;
   logic [1:0] reload_cnt_r;
   logic [1:0] reload_cnt_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic rvalid_r;
   logic rvalid_nxt;

   logic wr_feat;
   logic wr_cmd;
   logic reload_busy;

   // Reload and reset restore the same words
   localparam logic [7:0] FEAT_RST = `HFCR_FEATURE_RST;
   localparam logic [7:0] CMD_RST = `HFCR_COMMAND_RST;

   function automatic logic [7:0] feature_word(input logic ind_en, input logic [2:0] dly, input logic ssc);
      logic [7:0] w;
      w = `HFCR_FEATURE_RST;
      w[`HFCR_FEAT_IND_EN_BIT] = ind_en;
      w[`HFCR_FEAT_DELAY_MSB:`HFCR_FEAT_DELAY_LSB] = dly;
      w[`HFCR_FEAT_SSC_DIS_BIT] = ssc;
      return w;
   endfunction

   assign reload_busy = (reload_state_r == hfcr_pkg::HFCR_RLD_BUSY);
   assign wr_feat = reg_wr_i && (reg_addr_i == `HFCR_FEATURE_OFS) && !reload_busy;
   assign wr_cmd = reg_wr_i && (reg_addr_i == `HFCR_COMMAND_OFS);

   always_comb begin
      indicator_output_enable_nxt = indicator_output_enable_r;
      power_reenable_delay_nxt = power_reenable_delay_r;
      phy_ssc_disable_nxt = phy_ssc_disable_r;
      config_in_progress_nxt = config_in_progress_r;
      reload_state_nxt = reload_state_r;
      reload_cnt_nxt = reload_cnt_r;
      if (wr_feat) begin
         indicator_output_enable_nxt = reg_wdata_i[`HFCR_FEAT_IND_EN_BIT];
         power_reenable_delay_nxt = reg_wdata_i[`HFCR_FEAT_DELAY_MSB:`HFCR_FEAT_DELAY_LSB];
         phy_ssc_disable_nxt = reg_wdata_i[`HFCR_FEAT_SSC_DIS_BIT];
      end
      if (wr_cmd && reg_wdata_i[`HFCR_CMD_CFG_BIT]) begin
         config_in_progress_nxt = 1'b0;
      end
      if (cfg_mode_enter_i) begin
         config_in_progress_nxt = 1'b1;
      end
      case (reload_state_r)
         hfcr_pkg::HFCR_RLD_IDLE: begin
            if (wr_cmd && reg_wdata_i[`HFCR_CMD_RELOAD_BIT]) begin
               reload_state_nxt = hfcr_pkg::HFCR_RLD_BUSY;
               reload_cnt_nxt = 2'(`HFCR_RELOAD_CYCLES - 1);
            end
         end
         hfcr_pkg::HFCR_RLD_BUSY: begin
            indicator_output_enable_nxt = FEAT_RST[`HFCR_FEAT_IND_EN_BIT];
            power_reenable_delay_nxt = FEAT_RST[`HFCR_FEAT_DELAY_MSB:`HFCR_FEAT_DELAY_LSB];
            phy_ssc_disable_nxt = FEAT_RST[`HFCR_FEAT_SSC_DIS_BIT];
            config_in_progress_nxt = cfg_mode_enter_i;
            if (reload_cnt_r == 2'h0) begin
               reload_state_nxt = hfcr_pkg::HFCR_RLD_IDLE;
            end else begin
               reload_cnt_nxt = reload_cnt_r - 2'h1;
            end
         end
         default: begin
            reload_state_nxt = hfcr_pkg::HFCR_RLD_IDLE;
         end
      endcase
   end

   always_comb begin
      rdata_nxt = 8'h00;
      rvalid_nxt = reg_rd_i;
      if (reg_rd_i) begin
         case (reg_addr_i)
            `HFCR_FEATURE_OFS: begin
               rdata_nxt = feature_word(indicator_output_enable_r, power_reenable_delay_r, phy_ssc_disable_r);
            end
            `HFCR_COMMAND_OFS: begin
               rdata_nxt[`HFCR_CMD_RELOAD_BIT] = reload_busy;
               rdata_nxt[`HFCR_CMD_CFG_BIT] = config_in_progress_r;
            end
            default: begin
               rdata_nxt = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         indicator_output_enable_r <= FEAT_RST[`HFCR_FEAT_IND_EN_BIT];
         power_reenable_delay_r <= FEAT_RST[`HFCR_FEAT_DELAY_MSB:`HFCR_FEAT_DELAY_LSB];
         phy_ssc_disable_r <= FEAT_RST[`HFCR_FEAT_SSC_DIS_BIT];
         config_in_progress_r <= CMD_RST[`HFCR_CMD_CFG_BIT];
         reload_state_r <= hfcr_pkg::HFCR_RLD_IDLE;
         reload_cnt_r <= 2'h0;
         rdata_r <= 8'h00;
         rvalid_r <= 1'b0;
      end else begin
         indicator_output_enable_r <= indicator_output_enable_nxt;
         power_reenable_delay_r <= power_reenable_delay_nxt;
         phy_ssc_disable_r <= phy_ssc_disable_nxt;
         config_in_progress_r <= config_in_progress_nxt;
         reload_state_r <= reload_state_nxt;
         reload_cnt_r <= reload_cnt_nxt;
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Port power re-enable timing
   hfcr_pkg::hfcr_pwr_state_t pwr_state_r;
   hfcr_pkg::hfcr_pwr_state_t pwr_state_nxt;
   logic [3:0] steps_r;
   logic [3:0] steps_nxt;
   logic pwr_en_r;
   logic pwr_en_nxt;
   logic step;
   logic [2:0] eff_delay;

   assign eff_delay = (otp_power_reenable_delay_i != 3'h0) ? otp_power_reenable_delay_i : power_reenable_delay_r;

   hfcr_step_timer #(
      .STEP_CYCLES(STEP_CYCLES)
   ) u_step (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .restart_i(charge_mode_change_i && pwr_state_r == hfcr_pkg::HFCR_PWR_ON),
      .step_o(step)
   );

   always_comb begin
      pwr_state_nxt = pwr_state_r;
      steps_nxt = steps_r;
      pwr_en_nxt = pwr_en_r;
      case (pwr_state_r)
         hfcr_pkg::HFCR_PWR_ON: begin
            pwr_en_nxt = 1'b1;
            if (charge_mode_change_i) begin
               pwr_en_nxt = 1'b0;
               // (field + 1) steps of 200 ms
               steps_nxt = {1'b0, eff_delay} + 4'h1;
               pwr_state_nxt = hfcr_pkg::HFCR_PWR_OFF_WAIT;
            end
         end
         hfcr_pkg::HFCR_PWR_OFF_WAIT: begin
            pwr_en_nxt = 1'b0;
            if (step) begin
               if (steps_r == 4'h1) begin
                  pwr_en_nxt = 1'b1;
                  pwr_state_nxt = hfcr_pkg::HFCR_PWR_ON;
               end
               steps_nxt = steps_r - 4'h1;
            end
         end
         default: begin
            pwr_state_nxt = hfcr_pkg::HFCR_PWR_ON;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         pwr_state_r <= hfcr_pkg::HFCR_PWR_ON;
         steps_r <= 4'h0;
         pwr_en_r <= 1'b1;
      end else begin
         pwr_state_r <= pwr_state_nxt;
         steps_r <= steps_nxt;
         pwr_en_r <= pwr_en_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Indicator pins and status outputs
   logic [NUM_IND-1:0] ind_r;
   logic [NUM_IND-1:0] ind_oe_r;
   logic conn_allow_r;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ind_r <= '0;
         ind_oe_r <= '0;
         conn_allow_r <= 1'b0;
      end else begin
         ind_r <= indicator_output_enable_nxt ? indicator_i : '0;
         ind_oe_r <= {NUM_IND{indicator_output_enable_nxt}};
         conn_allow_r <= !config_in_progress_nxt;
      end
   end

   assign indicator_o = ind_r;
   assign indicator_oe_o = ind_oe_r;
   assign upstream_connect_allow_o = conn_allow_r;
   assign phy_ssc_disable_o = phy_ssc_disable_r;
   assign config_in_progress_o = config_in_progress_r;
   assign port_power_switch_enable_o = pwr_en_r;
   assign reload_busy_o = reload_busy;
   assign reg_rdata_o = rdata_r;
   assign reg_rvalid_o = rvalid_r;
endmodule

// [testbench/hfcr_host_model.sv]
// Behavioural configuration host driving the register strobes
`timescale 1ns/10ps
module hfcr_host_model (
   // Clock
   input wire logic clk_i,
   // Register access
   output logic reg_wr_o,
   output logic reg_rd_o,
   output logic [7:0] reg_addr_o,
   output logic [7:0] reg_wdata_o,
   input wire logic [7:0] reg_rdata_i
);
   initial begin
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_addr_o = 8'h00;
      reg_wdata_o = 8'h00;
   end

   task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      @(negedge clk_i);
      reg_wr_o = wr;
      reg_rd_o = !wr;
      reg_addr_o = a;
      reg_wdata_o = d;
      @(negedge clk_i);
      q = reg_rdata_i;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      // Released lines wander so stale values never pass for live ones
      reg_addr_o = ~a;
      reg_wdata_o = ~d;
   endtask
endmodule

// [testbench/hfcr_feature_cmd_regs_sva.sv]
// Port checker for the feature and command register bank
`timescale 1ns/10ps
module hfcr_regs_sva #(
   parameter int unsigned STEP_CYCLES = 10,
   parameter int unsigned NUM_IND = 4
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // Register access
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic reg_rvalid_o,
   // Mode, OTP and power
   input wire logic cfg_mode_enter_i,
   input wire logic [2:0] otp_power_reenable_delay_i,
   input wire logic charge_mode_change_i,
   input wire logic port_power_switch_enable_o,
   input wire logic reload_busy_o,
   // Indicators and status
   input wire logic [NUM_IND-1:0] indicator_i,
   input wire logic [NUM_IND-1:0] indicator_o,
   input wire logic [NUM_IND-1:0] indicator_oe_o,
   input wire logic phy_ssc_disable_o,
   input wire logic upstream_connect_allow_o,
   input wire logic config_in_progress_o
);
   int unsigned low_cnt_r, low_cnt_nxt;
   logic clr_seen_r, clr_seen_nxt;

   // Counts power-off cycles so long spans need no deep repetition
   always_comb begin
      low_cnt_nxt = port_power_switch_enable_o ? 0 : low_cnt_r + 1;
      clr_seen_nxt = reg_wr_i && reg_addr_i == 8'hF8 && reg_wdata_i[0];
   end
   always_ff @(posedge clk_i) begin
      low_cnt_r <= srst_i ? 0 : low_cnt_nxt;
      clr_seen_r <= srst_i ? 1'b0 : clr_seen_nxt;
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);

   a_read_valid: assert property (reg_rd_i |=> reg_rvalid_o) else $error("read not answered");
   a_unmapped_zero: assert property (reg_rd_i && reg_addr_i != 8'hF0 && reg_addr_i != 8'hF8
      |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
   a_feat_rsvd_zero: assert property (reg_rd_i && reg_addr_i == 8'hF0 |=> reg_rdata_o[7:5] == 3'h0)
      else $error("feature reserved bits set");
   a_cmd_rsvd_zero: assert property (reg_rd_i && reg_addr_i == 8'hF8 |=> reg_rdata_o[7:2] == 6'h00)
      else $error("command reserved bits set");
   a_oe_uniform: assert property (indicator_oe_o == '0 || indicator_oe_o == '1) else $error("oe split");
   a_ind_quiet: assert property (indicator_oe_o == '0 |-> indicator_o == '0) else $error("idle pin driven");
   a_cfg_set: assert property (cfg_mode_enter_i |=> config_in_progress_o) else $error("flag not set");
   a_cfg_clear: assert property ($fell(config_in_progress_o) |-> clr_seen_r || reload_busy_o)
      else $error("flag cleared without cause");
   // Connect permission moves in the same cycle as the flag
   a_connect_hold: assert property (config_in_progress_o |-> !upstream_connect_allow_o)
      else $error("connect during config");
   a_connect_free: assert property (!config_in_progress_o && !cfg_mode_enter_i |=> upstream_connect_allow_o)
      else $error("connect withheld");
   a_reload_start: assert property (reg_wr_i && reg_addr_i == 8'hF8 && reg_wdata_i[1] |=> reload_busy_o)
      else $error("reload not started");
   a_reload_len: assert property ($rose(reload_busy_o) |-> reload_busy_o[*2] ##1 !reload_busy_o)
      else $error("reload length wrong");
   a_power_drop: assert property (charge_mode_change_i && port_power_switch_enable_o
      |=> !port_power_switch_enable_o) else $error("power not dropped");
   a_power_otp: assert property ($rose(port_power_switch_enable_o) && otp_power_reenable_delay_i != 3'h0
      |-> low_cnt_r >= (otp_power_reenable_delay_i + 1) * STEP_CYCLES
      && low_cnt_r <= (otp_power_reenable_delay_i + 1) * STEP_CYCLES + 2) else $error("otp span wrong");
   a_power_max: assert property (low_cnt_r <= 8 * STEP_CYCLES + 2) else $error("power off too long");

   c_reload: cover property ($rose(reload_busy_o));
   c_cfg_clear: cover property ($fell(config_in_progress_o));
   c_power_back: cover property ($rose(port_power_switch_enable_o));
endmodule

bind hfcr_feature_cmd_regs hfcr_regs_sva #(.STEP_CYCLES(STEP_CYCLES), .NUM_IND(NUM_IND)) chk (.clk_i(clk_i),
   .srst_i(srst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .cfg_mode_enter_i(cfg_mode_enter_i),
   .otp_power_reenable_delay_i(otp_power_reenable_delay_i), .charge_mode_change_i(charge_mode_change_i),
   .port_power_switch_enable_o(port_power_switch_enable_o), .reload_busy_o(reload_busy_o),
   .indicator_i(indicator_i), .indicator_o(indicator_o), .indicator_oe_o(indicator_oe_o),
   .phy_ssc_disable_o(phy_ssc_disable_o), .upstream_connect_allow_o(upstream_connect_allow_o),
   .config_in_progress_o(config_in_progress_o));

// [testbench/hfcr_feature_cmd_regs_tb.sv]
// Self-checking bench for the feature and command register bank
`timescale 1ns/10ps
module hfcr_feature_cmd_regs_tb;
   localparam int unsigned STEP = 10;
   logic clk_i, srst_i, reg_wr_i, reg_rd_i, cfg_mode_enter_i, charge_mode_change_i;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, q, d;
   logic [2:0] otp_power_reenable_delay_i;
   logic [3:0] indicator_i, indicator_o, indicator_oe_o;
   logic reg_rvalid_o, port_power_switch_enable_o, reload_busy_o, phy_ssc_disable_o;
   logic upstream_connect_allow_o, config_in_progress_o;
   logic [31:0] seed;
   int mismatches, num_checks, n;

   hfcr_feature_cmd_regs #(.STEP_CYCLES(STEP)) uut (.clk_i(clk_i), .srst_i(srst_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
      .reg_rvalid_o(reg_rvalid_o), .cfg_mode_enter_i(cfg_mode_enter_i),
      .otp_power_reenable_delay_i(otp_power_reenable_delay_i), .charge_mode_change_i(charge_mode_change_i),
      .port_power_switch_enable_o(port_power_switch_enable_o), .reload_busy_o(reload_busy_o),
      .indicator_i(indicator_i), .indicator_o(indicator_o), .indicator_oe_o(indicator_oe_o),
      .phy_ssc_disable_o(phy_ssc_disable_o), .upstream_connect_allow_o(upstream_connect_allow_o),
      .config_in_progress_o(config_in_progress_o));
   hfcr_host_model host (.clk_i(clk_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i),
      .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o));

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic chk_rng(input string name, input int lo, input int got);
      num_checks++;
      if (got < lo || got > lo + 2) begin
         mismatches++;
         $display("mismatch %s expected %0d seen %0d", name, lo, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      host.access(1'b1, a, v, q);
   endtask

   task automatic rd(input logic [7:0] a);
      host.access(1'b0, a, 8'h00, q);
   endtask

   task automatic pulse_cfg();
      @(negedge clk_i);
      cfg_mode_enter_i = 1'b1;
      @(negedge clk_i);
      cfg_mode_enter_i = 1'b0;
      @(negedge clk_i);
   endtask

   task automatic pwr(input logic [2:0] field, input logic [2:0] otp);
      wr(8'hF0, {4'h0, field, 1'b0});
      otp_power_reenable_delay_i = otp;
      @(negedge clk_i);
      charge_mode_change_i = 1'b1;
      @(negedge clk_i);
      charge_mode_change_i = 1'b0;
      n = 0;
      while (port_power_switch_enable_o !== 1'b1 && n < 200) begin
         @(negedge clk_i);
         n++;
      end
      chk_rng("power off span", ((otp != 3'h0 ? otp : field) + 1) * STEP, n);
   endtask

   task automatic test_done();
      if (mismatches == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk_i);
      mismatches++;
      test_done();
   end

   initial begin
      seed = 32'h0000B05A;
      srst_i = 1'b1;
      cfg_mode_enter_i = 1'b0;
      charge_mode_change_i = 1'b0;
      otp_power_reenable_delay_i = 3'h0;
      indicator_i = 4'h0;
      mismatches = 0;
      num_checks = 0;
      repeat (20) @(negedge clk_i);
      srst_i = 1'b0;
      rd(8'hF0);
      chk("feature reset", 8'h00, q);
      rd(8'hF8);
      chk("command reset", 8'h00, q);
      chk("connect idle", 8'h01, {7'h00, upstream_connect_allow_o});
      for (int i = 0; i < 12; i++) begin
         seed = xs(seed);
         d = i == 0 ? 8'hFF : (i == 1 ? 8'h00 : seed[7:0]);
         indicator_i = seed[11:8];
         wr(8'hF0, d);
         rd(8'hF0);
         chk("feature readback", d & 8'h1F, q);
         chk("ssc disable", {7'h00, d[0]}, {7'h00, phy_ssc_disable_o});
         chk("indicator enable", {4'h0, {4{d[4]}}}, {4'h0, indicator_oe_o});
         chk("indicator value", {4'h0, d[4] ? seed[11:8] : 4'h0}, {4'h0, indicator_o});
         rd({1'b0, seed[18:12]});
         chk("unmapped read", 8'h00, q);
      end
      wr(8'hF8, 8'hFC);
      rd(8'hF8);
      chk("command zero write", 8'h00, q);
      pulse_cfg();
      chk("config flag set", 8'h01, {7'h00, config_in_progress_o});
      chk("connect held", 8'h00, {7'h00, upstream_connect_allow_o});
      wr(8'hF8, 8'hFC);
      rd(8'hF8);
      chk("flag kept", 8'h01, q);
      wr(8'hF8, 8'h01);
      rd(8'hF8);
      chk("flag cleared", 8'h00, q);
      chk("connect free", 8'h01, {7'h00, upstream_connect_allow_o});
      wr(8'hF0, 8'h1F);
      pulse_cfg();
      wr(8'hF8, 8'h02);
      chk("reload busy", 8'h01, {7'h00, reload_busy_o});
      n = 0;
      while (reload_busy_o === 1'b1 && n < 20) begin
         @(negedge clk_i);
         n++;
      end
      // Reload lasts two cycles, counted from the write edge
      chk("reload span", 8'h02, 8'(n));
      rd(8'hF0);
      chk("feature reloaded", 8'h00, q);
      rd(8'hF8);
      chk("reload self clear", 8'h00, q);
      seed = xs(seed);
      pwr(3'h0, 3'h0);
      pwr(3'h7, 3'h0);
      pwr(seed[2:0], 3'h0);
      pwr(3'h2, 3'h3);
      test_done();
   end
endmodule
